// file: core/adc_fine_gain_trim_regs.sv
// fine gain trim register bank for converter cores 0 to 5, Avalon-MM slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fine_gain_consts.svh"

// Operation
// [RULE1] Software writes zero into bits 7:5 of every trim register since they hold no code.
// [RULE2] Each register keeps a read/write 5-bit code in bits 4:0, reset zero, driving its core.
// [RULE3] Core 2 uses its input A register while sampling input A and its input B one otherwise.
// [RULE4] Core 3 uses its input C register while sampling input C and its input D one otherwise.
// [RULE5] Cores 1 to 5 sit at consecutive byte addresses 0x361 to 0x367 in the documented order.
// [RULE6] After reset every register is filled from factory fuse memory before software access.
// [RULE7] Core 0 sits at byte address 0x360, just below core 1.
// [RULE8] A written code reaches its core output right after the write with no commit step.
module adc_fine_gain_trim_regs
    import fine_gain_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             fuse_read,
    output logic      [2:0]  fuse_slot,
    input  wire logic [7:0]  fuse_data,
    input  wire logic        fuse_valid,
    output logic             trim_loaded,
    input  wire logic        core2_sampling_analog_input_b,
    input  wire logic        core3_sampling_analog_input_d,
    output logic      [4:0]  trim_code_core0,
    output logic      [4:0]  trim_code_core1,
    output logic      [4:0]  trim_code_core2,
    output logic      [4:0]  trim_code_core3,
    output logic      [4:0]  trim_code_core4,
    output logic      [4:0]  trim_code_core5
);

    // ****************************************
    // address decode
    // ****************************************

    // {hit, slot}; each register owns one byte address, data rides on lane 0
    function automatic logic [3:0] decode(input logic [11:0] addr);
        logic [3:0] res;
        res = 4'h0;
        begin
            case (addr)
                `IDX_FINE_GAIN_ADC0:         res = {1'b1, `SLOT_ADC0};   // RULE7
                `IDX_FINE_GAIN_ADC1:         res = {1'b1, `SLOT_ADC1};   // RULE5
                `IDX_FINE_GAIN_ADC2_INPUT_A: res = {1'b1, `SLOT_ADC2_A}; // RULE5
                `IDX_FINE_GAIN_ADC2_INPUT_B: res = {1'b1, `SLOT_ADC2_B}; // RULE5
                `IDX_FINE_GAIN_ADC3_INPUT_C: res = {1'b1, `SLOT_ADC3_C}; // RULE5
                `IDX_FINE_GAIN_ADC3_INPUT_D: res = {1'b1, `SLOT_ADC3_D}; // RULE5
                `IDX_FINE_GAIN_ADC4:         res = {1'b1, `SLOT_ADC4};   // RULE5
                `IDX_FINE_GAIN_ADC5:         res = {1'b1, `SLOT_ADC5};   // RULE5
                default:                     res = 4'h0;
            endcase
        end
        return res;
    endfunction

    // ****************************************
    // submodules
    // ****************************************

    store_wr_t   load_wr;
    store_wr_t   bus_wr;
    store_wr_t   store_wr;
    logic [7:0]  store_rd_data;
    logic [63:0] store_contents;
    logic [3:0]  hit_slot;

    assign hit_slot = decode(avs_address);

    fuse_loader u_fuse_loader (
        .clk        (clk),
        .rst_n      (rst_n),
        .fuse_read  (fuse_read),
        .fuse_slot  (fuse_slot),
        .fuse_data  (fuse_data),
        .fuse_valid (fuse_valid),
        .wr         (load_wr),
        .loaded     (trim_loaded)
    );

    // the bus is held off until loading ends, so the two writers never collide
    assign store_wr = trim_loaded ? bus_wr : load_wr; // RULE6

    trim_store u_trim_store (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr       (store_wr),
        .rd_slot  (hit_slot[2:0]),
        .rd_data  (store_rd_data),
        .contents (store_contents)
    );

    // ****************************************
    // Avalon-MM slave
    // ****************************************

    bus_state_t  bus_state;
    bus_state_t  next_bus_state;
    logic [31:0] next_avs_readdata;
    logic        next_avs_waitrequest;

    // write lands at the edge where the master sees waitrequest low
    always_comb begin
        bus_wr      = '0;
        bus_wr.slot = hit_slot[2:0];
        // whole byte stored; reserved bits stay writable and read back
        bus_wr.data = avs_writedata[7:0]; // RULE2
        if (bus_state == BUS_ACK && avs_write && hit_slot[3] && avs_byteenable[0]) begin
            bus_wr.en = 1'b1; // RULE2
        end
    end

    always_comb begin
        next_bus_state       = bus_state;
        next_avs_readdata    = avs_readdata;
        next_avs_waitrequest = 1'b1;
        case (bus_state)
            BUS_IDLE: begin
                if (trim_loaded && (avs_read || avs_write)) begin // RULE6
                    next_bus_state = BUS_FETCH;
                end
            end
            BUS_FETCH: begin
                // store read data became valid at this edge
                next_avs_readdata = `READ_UNMAPPED;
                if (avs_read && hit_slot[3]) begin
                    next_avs_readdata = {24'h00_0000, store_rd_data};
                end
                next_avs_waitrequest = 1'b0;
                next_bus_state       = BUS_ACK;
            end
            BUS_ACK: begin
                next_bus_state = BUS_IDLE;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state       <= BUS_IDLE;
            avs_readdata    <= `READ_UNMAPPED;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state       <= next_bus_state;
            avs_readdata    <= next_avs_readdata;
            avs_waitrequest <= next_avs_waitrequest;
        end
    end

    // ****************************************
    // trim codes toward the converter cores
    // ****************************************

    function automatic logic [4:0] code_of(input logic [63:0] c, input logic [2:0] slot);
        logic [7:0] b;
        b = c[slot*8 +: 8];
        return b[`TRIM_CODE_MSB:`TRIM_CODE_LSB];
    endfunction

    logic [4:0] next_code0;
    logic [4:0] next_code1;
    logic [4:0] next_code2;
    logic [4:0] next_code3;
    logic [4:0] next_code4;
    logic [4:0] next_code5;

    // follows the store every cycle, so a write shows one edge later
    always_comb begin
        next_code0 = code_of(store_contents, `SLOT_ADC0); // RULE8
        next_code1 = code_of(store_contents, `SLOT_ADC1);
        next_code2 = core2_sampling_analog_input_b ?
                     code_of(store_contents, `SLOT_ADC2_B) :
                     code_of(store_contents, `SLOT_ADC2_A); // RULE3
        next_code3 = core3_sampling_analog_input_d ?
                     code_of(store_contents, `SLOT_ADC3_D) :
                     code_of(store_contents, `SLOT_ADC3_C); // RULE4
        next_code4 = code_of(store_contents, `SLOT_ADC4);
        next_code5 = code_of(store_contents, `SLOT_ADC5);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_code_core0 <= 5'h00;
            trim_code_core1 <= 5'h00;
            trim_code_core2 <= 5'h00;
            trim_code_core3 <= 5'h00;
            trim_code_core4 <= 5'h00;
            trim_code_core5 <= 5'h00;
        end else begin
            trim_code_core0 <= next_code0;
            trim_code_core1 <= next_code1;
            trim_code_core2 <= next_code2;
            trim_code_core3 <= next_code3;
            trim_code_core4 <= next_code4;
            trim_code_core5 <= next_code5;
        end
    end

endmodule // adc_fine_gain_trim_regs

`default_nettype wire

// file: core/fine_gain_consts.svh
// constants for the fine gain trim register bank
`ifndef FINE_GAIN_CONSTS_SVH
`define FINE_GAIN_CONSTS_SVH

// ****************************************
// register byte addresses, one register per byte
// ****************************************
`define IDX_FINE_GAIN_ADC0          12'h360
`define IDX_FINE_GAIN_ADC1          12'h361
`define IDX_FINE_GAIN_ADC2_INPUT_A  12'h362
`define IDX_FINE_GAIN_ADC2_INPUT_B  12'h363
`define IDX_FINE_GAIN_ADC3_INPUT_C  12'h364
`define IDX_FINE_GAIN_ADC3_INPUT_D  12'h365
`define IDX_FINE_GAIN_ADC4          12'h366
`define IDX_FINE_GAIN_ADC5          12'h367

// ****************************************
// slots inside the trim store
// ****************************************
`define SLOT_ADC0                   3'h0
`define SLOT_ADC1                   3'h1
`define SLOT_ADC2_A                 3'h2
`define SLOT_ADC2_B                 3'h3
`define SLOT_ADC3_C                 3'h4
`define SLOT_ADC3_D                 3'h5
`define SLOT_ADC4                   3'h6
`define SLOT_ADC5                   3'h7
`define SLOT_LAST                   3'h7

// ****************************************
// fields and reset values
// ****************************************
`define TRIM_CODE_MSB               4
`define TRIM_CODE_LSB               0
`define TRIM_RESERVED_MSB           7
`define TRIM_RESERVED_LSB           5
`define TRIM_CODE_MASK              8'h1F
`define TRIM_RESET                  8'h00
`define READ_UNMAPPED               32'h0000_0000

`endif

// file: core/fine_gain_pkg.sv
// types shared by the fine gain trim register bank
package fine_gain_pkg;

    // ****************************************
    // state machines
    // ****************************************
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_FETCH = 2'b01,
        BUS_ACK   = 2'b10
    } bus_state_t;

    typedef enum logic [1:0] {
        LOAD_REQ  = 2'b00,
        LOAD_WAIT = 2'b01,
        LOAD_DONE = 2'b10
    } load_state_t;

    // ****************************************
    // write port of the trim store
    // ****************************************
    typedef struct packed {
        logic       en;
        logic [2:0] slot;
        logic [7:0] data;
    } store_wr_t;

endpackage

// file: core/trim_store.sv
// eight-byte trim store with registered read port and parallel contents
`timescale 1ns/1ps
`default_nettype none
`include "fine_gain_consts.svh"

module trim_store
    import fine_gain_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire store_wr_t   wr,
    input  wire logic [2:0]  rd_slot,
    output logic      [7:0]  rd_data,
    output logic      [63:0] contents
);

    logic [7:0] mem      [8];
    logic [7:0] next_mem [8];
    logic [7:0] next_rd_data;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr.en) begin
            next_mem[wr.slot] = wr.data;
        end
        next_rd_data = mem[rd_slot];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                mem[i] <= `TRIM_RESET;
            end
            rd_data <= `TRIM_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                mem[i] <= next_mem[i];
            end
            rd_data <= next_rd_data;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            contents[i*8 +: 8] = mem[i];
        end
    end

endmodule // trim_store

`default_nettype wire

// file: core/fuse_loader.sv
// copies factory fuse defaults into the trim store after reset
`timescale 1ns/1ps
`default_nettype none
`include "fine_gain_consts.svh"

module fuse_loader
    import fine_gain_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    output logic            fuse_read,
    output logic      [2:0] fuse_slot,
    input  wire logic [7:0] fuse_data,
    input  wire logic       fuse_valid,
    output store_wr_t       wr,
    output logic            loaded
);

    load_state_t state;
    load_state_t next_state;
    logic        next_fuse_read;
    logic [2:0]  next_fuse_slot;
    store_wr_t   next_wr;
    logic        next_loaded;

    always_comb begin
        next_state     = state;
        next_fuse_read = fuse_read;
        next_fuse_slot = fuse_slot;
        next_loaded    = loaded;
        next_wr        = '0;
        case (state)
            LOAD_REQ: begin
                next_fuse_read = 1'b1;
                next_state     = LOAD_WAIT;
            end
            LOAD_WAIT: begin
                if (fuse_valid) begin
                    next_fuse_read = 1'b0;
                    next_wr.en     = 1'b1;
                    next_wr.slot   = fuse_slot;
                    // reserved bits keep their reset value whatever the fuse holds
                    next_wr.data   = fuse_data & `TRIM_CODE_MASK;
                    // loaded rises one edge later so the last byte still reaches the store
                    if (fuse_slot == `SLOT_LAST) begin
                        next_state  = LOAD_DONE;
                    end else begin
                        next_fuse_slot = fuse_slot + 3'h1;
                        next_state     = LOAD_REQ;
                    end
                end
            end
            LOAD_DONE: begin
                next_loaded = 1'b1;
            end
            default: begin
                next_state = LOAD_DONE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= LOAD_REQ;
            fuse_read <= 1'b0;
            fuse_slot <= 3'h0;
            wr        <= '0;
            loaded    <= 1'b0;
        end else begin
            state     <= next_state;
            fuse_read <= next_fuse_read;
            fuse_slot <= next_fuse_slot;
            wr        <= next_wr;
            loaded    <= next_loaded;
        end
    end

endmodule // fuse_loader

`default_nettype wire

// file: sim/fine_gain_checker.sv
// assertions on the ports of the fine gain trim register bank
`timescale 1ns/1ps
`default_nettype none
module fine_gain_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        fuse_read,
    input wire logic [2:0]  fuse_slot,
    input wire logic        fuse_valid,
    input wire logic        trim_loaded,
    input wire logic [4:0]  trim_code_core0
);
    // ****************************************
    // bus, fuse and core 0 trim code port properties
    // ****************************************
    logic wack;
    assign wack = avs_write && !avs_waitrequest;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (avs_read || avs_write) && trim_loaded && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_last_fuse;
        fuse_read && fuse_valid && fuse_slot == 3'h7;
    endsequence
    a_locked_till_load: assert property (!trim_loaded |-> avs_waitrequest)
        else $error("bus answered before fuse load");
    a_answer_one_cycle: assert property (s_req |-> ##[1:3] s_ack)
        else $error("bus answer missing or too long");
    a_read_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_readdata_hold: assert property (!avs_read && !avs_write |=> $stable(avs_readdata))
        else $error("read data changed without a transfer");
    a_fuse_req_hold: assert property (fuse_read && !fuse_valid |=> fuse_read && $stable(fuse_slot))
        else $error("fuse request dropped early");
    a_fuse_slot_order: assert property (fuse_read && fuse_valid && fuse_slot != 3'h7 |=>
        !fuse_read ##1 (fuse_read && fuse_slot == $past(fuse_slot, 2) + 3'h1))
        else $error("fuse slots out of order");
    a_load_ends: assert property (s_last_fuse |-> ##[1:2] (trim_loaded && !fuse_read))
        else $error("load did not finish after last slot");
    a_loaded_sticks: assert property (trim_loaded |=> trim_loaded && !fuse_read)
        else $error("fuse load restarted");
    a_code_on_write: assert property ($changed(trim_code_core0) && trim_loaded && $past(trim_loaded, 3)
        |-> $past(wack, 2) || $past(wack, 3))
        else $error("core 0 code changed without a write");
endmodule // fine_gain_checker

bind adc_fine_gain_trim_regs fine_gain_checker u_chk (.clk, .rst_n, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .fuse_read, .fuse_slot, .fuse_valid, .trim_loaded,
    .trim_code_core0);
`default_nettype wire

// file: sim/test_adc_fine_gain_trim_regs.sv
// self-checking bench for the fine gain trim register bank
`timescale 1ns/1ps
`default_nettype none
module test_adc_fine_gain_trim_regs;
    // ****************************************
    // stimulus, model and checks
    // ****************************************
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [7:0]  fuse_data = 8'h00;
    logic        fuse_valid = 1'b0;
    logic        sel_b = 1'b0;
    logic        sel_d = 1'b0;
    logic [31:0] avs_readdata, rdv, v;
    logic        avs_waitrequest, fuse_read, trim_loaded;
    logic [2:0]  fuse_slot;
    logic [4:0]  c0, c1, c2, c3, c4, c5;
    logic [31:0] seed = 32'hFE65;
    int          fails = 0;
    int          compares = 0;
    int          n;
    int          m[8];

    adc_fine_gain_trim_regs DUT (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fuse_read,
        .fuse_slot, .fuse_data, .fuse_valid, .trim_loaded,
        .core2_sampling_analog_input_b(sel_b), .core3_sampling_analog_input_d(sel_d),
        .trim_code_core0(c0), .trim_code_core1(c1), .trim_code_core2(c2),
        .trim_code_core3(c3), .trim_code_core4(c4), .trim_code_core5(c5));

    always #20 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [11:0] addr(input int i);
        return 12'h360 + 12'(i);
    endfunction

    task conclude;
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task limit(input int cnt);
        if (cnt >= 200) begin
            fails++;
            conclude;
        end
    endtask

    // request held until waitrequest is seen low at an edge
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        limit(n);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task check_codes(input int w);
        repeat (w) @(posedge clk);
        @(negedge clk);
        cmp(c0, m[0]);
        cmp(c1, m[1]);
        cmp(c2, sel_b ? m[3] : m[2]);
        cmp(c3, sel_d ? m[5] : m[4]);
        cmp(c4, m[6]);
        cmp(c5, m[7]);
    endtask

    task read_all;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, addr(i), 32'h0, 4'hF);
            cmp(rdv, m[i]);
        end
    endtask

    initial begin
        for (int i = 0; i < 8; i++) m[i] = 0;
        repeat (19) @(posedge clk);
        check_codes(0);
        cmp(avs_waitrequest, 1'b1);
        @(posedge clk);
        rst_n <= 1'b1;
        // fuse memory answers after a random delay
        for (int i = 0; i < 8; i++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (fuse_read !== 1'b1 && n < 200);
            limit(n);
            cmp(fuse_slot, i);
            repeat (rnd() % 3) @(posedge clk);
            v = rnd();
            fuse_data <= v[7:0];
            m[i] = v[4:0];
            fuse_valid <= 1'b1;
            @(posedge clk);
            fuse_valid <= 1'b0;
        end
        n = 0;
        while (trim_loaded !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        limit(n);
        check_codes(2);
        read_all;
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            bus(1'b1, addr(i), {27'h0, v[4:0]}, 4'hF);
            m[i] = v[4:0];
            check_codes(2);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            sel_b <= i[0];
            sel_d <= i[1];
            check_codes(2);
        end
        // refused writes: lane 0 off, just below and just past the bank
        bus(1'b1, addr(1), 32'(m[1] ^ 21), 4'hE);
        bus(1'b1, 12'h35F, 32'h0000_0015, 4'hF);
        bus(1'b1, 12'h368, 32'h0000_0015, 4'hF);
        bus(1'b0, 12'h35F, 32'h0, 4'hF);
        cmp(rdv, 32'h0);
        bus(1'b0, 12'h368, 32'h0, 4'hF);
        cmp(rdv, 32'h0);
        read_all;
        check_codes(2);
        conclude;
    end
endmodule // test_adc_fine_gain_trim_regs
`default_nettype wire
